// File: shared/fc_map.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * fault capture and alert block, as `define macros.
 * Assumes a 250 MHz core clock and byte addresses on the host port.
 */
`ifndef FC_MAP_SVH
`define FC_MAP_SVH

// ==========================================================
// Clock and timing
`define FC_CLK_MHZ          250
`define FC_FLASH_WR_MIN_US  700
`define FC_FLASH_WR_MAX_US  1400
`define FC_FLASH_WR_CYC     (`FC_FLASH_WR_MAX_US * `FC_CLK_MHZ)

// ==========================================================
// Record and options layout
`define FC_REC_BYTES        8'h16
`define FC_REC_BITS         176
`define FC_OPT_CAP_EN_BIT   1
`define FC_OPT_RESET        8'h00
`define FC_CAP_CTRL_LOAD    8'h01
`define FC_CAP_CTRL_STORE   8'h02
// Arbitrary value
`define FC_DEV_ADDR         7'h20

// ==========================================================
// Host register map (byte addresses)
`define FC_REG_CTRL         8'h00
`define FC_REG_CMD          8'h04
`define FC_REG_STATUS       8'h08
`define FC_REG_IRQ_STAT     8'h0C
`define FC_REG_IRQ_CLR      8'h10
`define FC_REG_IRQ_EN       8'h14
`define FC_REG_DATA         8'h40
`define FC_DATA_WORDS       23
`define FC_CTRL_AUTO_BIT    0
`define FC_IRQ_DONE_BIT     0
`define FC_IRQ_ALERT_BIT    1
`define FC_IRQ_ARA_BIT      2

`endif

// File: shared/fc_pkg.sv
/*
 * Types shared by both ends of the management link.
 * Assumes fc_map.svh for all numeric values.
 */
package fc_pkg;

   // ==========================================================
   // Management commands
   typedef enum logic [2:0] {
      FC_CMD_OPTIONS,
      FC_CMD_CAP_CTRL,
      FC_CMD_CAP_READ,
      FC_CMD_TELEM,
      FC_CMD_ARA
   } fc_cmd_t;

   typedef enum logic [1:0] {
      FC_D_IDLE,
      FC_D_SEND,
      FC_D_LOAD,
      FC_D_FLASH
   } fc_dev_state_t;

   typedef enum logic [1:0] {
      FC_H_IDLE,
      FC_H_REQ,
      FC_H_WAIT
   } fc_host_state_t;

endpackage

// File: shared/fc_mgmt_if.sv
/*
 * Management link between the host controller and the device:
 * command handshake, byte answer stream and the open-drain alert.
 * Assumes one device; a pull-up gives the released alert level.
 */
`timescale 1ns/1ps
interface fc_mgmt_if;
   logic              cmd_valid;
   logic              cmd_ready;
   fc_pkg::fc_cmd_t   cmd_code;
   logic [7:0]        cmd_data;
   logic              rsp_valid;
   logic [7:0]        rsp_byte;
   logic              rsp_last;
   logic              alert_o;
   logic              alert_oe;
   logic              fault_alert_line;

   // ==========================================================
   // Open-drain wire with pull-up
   assign fault_alert_line = alert_oe ? alert_o : 1'b1;

   modport device (
      input  cmd_valid,
      input  cmd_code,
      input  cmd_data,
      input  fault_alert_line,
      output cmd_ready,
      output rsp_valid,
      output rsp_byte,
      output rsp_last,
      output alert_o,
      output alert_oe
   );

   modport host (
      output cmd_valid,
      output cmd_code,
      output cmd_data,
      input  fault_alert_line,
      input  cmd_ready,
      input  rsp_valid,
      input  rsp_byte,
      input  rsp_last
   );
endinterface

// File: rtl/fc_flash_store.sv
/*
 * Non-volatile store for one capture record with a write busy time.
 * Assumes write and read pulses are never given while busy.
 */
`timescale 1ns/1ps
`include "fc_map.svh"
module fc_flash_store #(
   parameter int WR_CYC = `FC_FLASH_WR_CYC
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   input  wire logic                     wr,
   input  wire logic                     rd,
   input  wire logic [`FC_REC_BITS-1:0]  wdata,
   output logic                          busy,
   output logic                          rd_valid,
   output logic [`FC_REC_BITS-1:0]       rdata
);
   typedef struct packed {
      logic                     busy;
      logic [18:0]              cnt;
      logic [21:0][7:0]         mem;
      logic                     rd_valid;
      logic [`FC_REC_BITS-1:0]  rdata;
   } fc_fl_st_t;

   fc_fl_st_t s;
   fc_fl_st_t next_s;

   // ==========================================================
   // Write timer; the full worst-case time is always waited
   always_comb begin
      next_s = s;
      next_s.rd_valid = 1'b0;
      if (wr && !s.busy) begin
         next_s.mem = wdata;
         next_s.busy = 1'b1;
         next_s.cnt = 19'(WR_CYC - 1);
      end else if (s.busy) begin
         if (s.cnt == 19'h0) begin
            next_s.busy = 1'b0;
         end else begin
            next_s.cnt = s.cnt - 19'h1;
         end
      end
      if (rd && !s.busy) begin
         next_s.rdata = s.mem;
         next_s.rd_valid = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.busy;
   assign rd_valid = s.rd_valid;
   assign rdata = s.rdata;
endmodule

// File: rtl/fc_device.sv
/*
 * Device end: fault alert, alert response, telemetry reads, capture
 * record with flash store and load.
 * Assumes the host keeps cmd_valid up until cmd_ready and that the
 * telemetry and status inputs are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "fc_map.svh"
// Behaviour
// - Options bit 1 enables capture
// - Record returned as one 22-byte block read
// - Record byte layout, reserved 31:22 unsent
// - Control value 1 loads record from flash
// - Control value 2 stores, only output disabled
// - Auto store on shutdown faults only
// - Flash write wait covers full 1400 us
// - Host loads before reading after power loss
// - Alert driven low on any fault, except one in the cycle of a response read while none is pending
// - Host answers alert with response address read
// - Alert repeats while several faults pending
// - Telemetry readable at any time; code holds commands off until a flash write ends
module fc_device #(
   parameter int FLASH_WR_CYC = `FC_FLASH_WR_CYC
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   fc_mgmt_if.device         mgmt,
   input  wire logic [15:0]  vin,
   input  wire logic [15:0]  vout,
   input  wire logic [15:0]  iout_avg,
   input  wire logic [15:0]  iout_peak,
   input  wire logic [15:0]  duty,
   input  wire logic [15:0]  temp_int,
   input  wire logic [15:0]  temp_ext,
   input  wire logic [15:0]  fsw,
   input  wire logic [7:0]   vout_status,
   input  wire logic [7:0]   iout_status,
   input  wire logic [7:0]   input_status,
   input  wire logic [7:0]   temp_status,
   input  wire logic [7:0]   comm_memory_logic_status_byte,
   input  wire logic [7:0]   mfr_status,
   input  wire logic         fault_event,
   input  wire logic         fault_shutdown,
   input  wire logic         output_enabled,
   output logic              capture_en,
   output logic              record_frozen,
   output logic              flash_busy
);
   typedef struct packed {
      fc_pkg::fc_dev_state_t    state;
      logic [7:0]               options;
      logic                     frozen;
      logic                     store_pend;
      logic [`FC_REC_BITS-1:0]  rec;
      logic [183:0]             tx;
      logic [4:0]               left;
      logic [1:0]               pend;
      logic                     alert_oe;
      logic                     cmd_ready;
      logic                     rsp_valid;
      logic [7:0]               rsp_byte;
      logic                     rsp_last;
      logic                     fl_wr;
      logic                     fl_rd;
      logic                     fl_busy;
   } fc_dev_st_t;

   fc_dev_st_t               s;
   fc_dev_st_t               next_s;
   logic [`FC_REC_BITS-1:0]  live;
   logic [7:0][15:0]         tel;
   logic                     cap_on;
   logic                     take;
   logic                     ara_win;
   logic                     fault_store;
   logic                     fl_busy;
   logic                     fl_rd_valid;
   logic [`FC_REC_BITS-1:0]  fl_rdata;

   // ==========================================================
   // Live record, high byte pair first down to byte 0
   assign live = {vin, vout, iout_avg, iout_peak, duty, temp_int,
                  temp_ext, fsw, vout_status, iout_status,
                  input_status, temp_status,
                  comm_memory_logic_status_byte,
                  mfr_status};
   assign tel = live[`FC_REC_BITS-1:48];
   assign cap_on = s.options[`FC_OPT_CAP_EN_BIT];
   assign take = mgmt.cmd_valid && s.cmd_ready;
   // Retry-configured faults never reach flash
   assign fault_store = cap_on && fault_event
                        && fault_shutdown;

   fc_flash_store #(
      .WR_CYC   (FLASH_WR_CYC)
   ) u_flash (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .wr       (s.fl_wr),
      .rd       (s.fl_rd),
      .wdata    (s.rec),
      .busy     (fl_busy),
      .rd_valid (fl_rd_valid),
      .rdata    (fl_rdata)
   );

   // ==========================================================
   // Command sequencer
   always_comb begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      next_s.rsp_last = 1'b0;
      next_s.rsp_byte = 8'h00;
      next_s.fl_wr = 1'b0;
      next_s.fl_rd = 1'b0;
      next_s.fl_busy = fl_busy;
      ara_win = 1'b0;
      if (cap_on && !s.frozen) begin
         next_s.rec = live;
      end
      if (fault_store) begin
         next_s.rec = live;
         next_s.frozen = 1'b1;
         next_s.store_pend = 1'b1;
      end
      case (s.state)
         fc_pkg::FC_D_IDLE: begin
            if (take) begin
               case (mgmt.cmd_code)
                  fc_pkg::FC_CMD_OPTIONS: begin
                     next_s.options = mgmt.cmd_data;
                     next_s.frozen = fault_store;
                  end
                  fc_pkg::FC_CMD_CAP_CTRL: begin
                     if (mgmt.cmd_data == `FC_CAP_CTRL_LOAD) begin
                        next_s.fl_rd = 1'b1;
                        next_s.state = fc_pkg::FC_D_LOAD;
                     end else if (mgmt.cmd_data == `FC_CAP_CTRL_STORE
                                  && !output_enabled) begin
                        next_s.store_pend = 1'b1;
                     end
                  end
                  fc_pkg::FC_CMD_CAP_READ: begin
                     // Count byte then bytes 0..21 in one burst
                     next_s.tx = {s.rec, `FC_REC_BYTES};
                     next_s.left = 5'(`FC_REC_BYTES);
                     next_s.state = fc_pkg::FC_D_SEND;
                  end
                  fc_pkg::FC_CMD_TELEM: begin
                     next_s.tx = {168'h0, tel[~mgmt.cmd_data[2:0]]};
                     next_s.left = 5'h01;
                     next_s.state = fc_pkg::FC_D_SEND;
                  end
                  fc_pkg::FC_CMD_ARA: begin
                     next_s.tx = {176'h0, `FC_DEV_ADDR, 1'b0};
                     next_s.left = 5'h00;
                     next_s.state = fc_pkg::FC_D_SEND;
                     ara_win = 1'b1;
                  end
                  default: begin
                     next_s.state = fc_pkg::FC_D_IDLE;
                  end
               endcase
            end else if (s.store_pend) begin
               next_s.fl_wr = 1'b1;
               next_s.store_pend = fault_store;
               next_s.state = fc_pkg::FC_D_FLASH;
            end
         end
         fc_pkg::FC_D_SEND: begin
            next_s.rsp_valid = 1'b1;
            next_s.rsp_byte = s.tx[7:0];
            next_s.tx = {8'h00, s.tx[183:8]};
            if (s.left == 5'h00) begin
               next_s.rsp_last = 1'b1;
               next_s.state = fc_pkg::FC_D_IDLE;
            end else begin
               next_s.left = s.left - 5'h01;
            end
         end
         fc_pkg::FC_D_LOAD: begin
            if (fl_rd_valid) begin
               next_s.rec = fl_rdata;
               next_s.frozen = 1'b1;
               next_s.state = fc_pkg::FC_D_IDLE;
            end
         end
         fc_pkg::FC_D_FLASH: begin
            // Busy rises one cycle after the write pulse
            if (!s.fl_wr && !fl_busy) begin
               next_s.state = fc_pkg::FC_D_IDLE;
            end
         end
         default: begin
            next_s.state = fc_pkg::FC_D_IDLE;
         end
      endcase

      // ========================================================
      // Alert pending count; a new fault beside a win keeps it
      if (fault_event && !ara_win && s.pend != 2'h3) begin
         next_s.pend = s.pend + 2'h1;
      end else if (ara_win && !fault_event && s.pend != 2'h0) begin
         next_s.pend = s.pend - 2'h1;
      end
      next_s.alert_oe = (next_s.pend != 2'h0);
      next_s.cmd_ready = (next_s.state == fc_pkg::FC_D_IDLE)
                         && !next_s.store_pend && !take;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign mgmt.cmd_ready = s.cmd_ready;
   assign mgmt.rsp_valid = s.rsp_valid;
   assign mgmt.rsp_byte = s.rsp_byte;
   assign mgmt.rsp_last = s.rsp_last;
   assign mgmt.alert_o = 1'b0;
   assign mgmt.alert_oe = s.alert_oe;
   assign capture_en = s.options[`FC_OPT_CAP_EN_BIT];
   assign record_frozen = s.frozen;
   assign flash_busy = s.fl_busy;
endmodule

// File: rtl/fc_host.sv
/*
 * Host end: software register port, command issue, answer capture,
 * automatic alert response reads and interrupt.
 * Assumes a single-cycle strobe master; read data one cycle later.
 */
`timescale 1ns/1ps
`include "fc_map.svh"
module fc_host (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   fc_mgmt_if.host           mgmt,
   input  wire logic [7:0]   addr,
   input  wire logic [31:0]  wdata,
   input  wire logic         wr,
   input  wire logic         rd,
   output logic [31:0]       rdata,
   output logic              irq
);
   typedef struct packed {
      fc_pkg::fc_host_state_t  state;
      logic                    auto_ara;
      fc_pkg::fc_cmd_t         code;
      logic [7:0]              data;
      logic                    cmd_valid;
      logic [22:0][7:0]        rx;
      logic [4:0]              cnt;
      logic [7:0]              ara_addr;
      logic                    alert_prev;
      logic [2:0]              stat;
      logic [2:0]              en;
      logic                    irq;
      logic [31:0]             rdata;
   } fc_host_st_t;

   fc_host_st_t  s;
   fc_host_st_t  next_s;
   logic [2:0]   ev;
   logic [7:0]   didx;
   logic         launch;

   assign didx = 8'(addr - `FC_REG_DATA) >> 2;

   always_comb begin
      next_s = s;
      ev = 3'h0;
      launch = 1'b0;
      next_s.rdata = 32'h0;
      next_s.alert_prev = mgmt.fault_alert_line;
      if (s.alert_prev && !mgmt.fault_alert_line) begin
         ev[`FC_IRQ_ALERT_BIT] = 1'b1;
      end

      // ========================================================
      // Register writes; a command while busy is dropped
      if (wr) begin
         case (addr)
            `FC_REG_CTRL: next_s.auto_ara = wdata[`FC_CTRL_AUTO_BIT];
            `FC_REG_CMD: begin
               if (s.state == fc_pkg::FC_H_IDLE) begin
                  next_s.code = fc_pkg::fc_cmd_t'(wdata[10:8]);
                  next_s.data = wdata[7:0];
                  launch = 1'b1;
               end
            end
            `FC_REG_IRQ_EN: next_s.en = wdata[2:0];
            default: next_s.en = s.en;
         endcase
      end

      // ========================================================
      // Link sequencer; alert low keeps response reads coming
      case (s.state)
         fc_pkg::FC_H_IDLE: begin
            if (!launch && s.auto_ara && !mgmt.fault_alert_line) begin
               next_s.code = fc_pkg::FC_CMD_ARA;
               launch = 1'b1;
            end
            if (launch) begin
               next_s.cmd_valid = 1'b1;
               next_s.state = fc_pkg::FC_H_REQ;
            end
         end
         fc_pkg::FC_H_REQ: begin
            if (mgmt.cmd_ready) begin
               next_s.cmd_valid = 1'b0;
               next_s.cnt = 5'h00;
               if (s.code == fc_pkg::FC_CMD_OPTIONS
                   || s.code == fc_pkg::FC_CMD_CAP_CTRL) begin
                  ev[`FC_IRQ_DONE_BIT] = 1'b1;
                  next_s.state = fc_pkg::FC_H_IDLE;
               end else begin
                  next_s.state = fc_pkg::FC_H_WAIT;
               end
            end
         end
         fc_pkg::FC_H_WAIT: begin
            if (mgmt.rsp_valid) begin
               if (s.cnt < 5'(`FC_DATA_WORDS)) begin
                  next_s.rx[s.cnt] = mgmt.rsp_byte;
                  next_s.cnt = s.cnt + 5'h01;
               end
               if (s.code == fc_pkg::FC_CMD_ARA) begin
                  next_s.ara_addr = mgmt.rsp_byte;
                  ev[`FC_IRQ_ARA_BIT] = 1'b1;
               end
               if (mgmt.rsp_last) begin
                  ev[`FC_IRQ_DONE_BIT] = 1'b1;
                  next_s.state = fc_pkg::FC_H_IDLE;
               end
            end
         end
         default: begin
            next_s.state = fc_pkg::FC_H_IDLE;
         end
      endcase

      // ========================================================
      // Sticky status; a new event beats a clear in the same cycle
      next_s.stat = s.stat;
      if (wr && addr == `FC_REG_IRQ_CLR) begin
         next_s.stat = s.stat & ~wdata[2:0];
      end
      next_s.stat = next_s.stat | ev;
      next_s.irq = |(next_s.stat & next_s.en);

      if (rd) begin
         if (addr == `FC_REG_CTRL) begin
            next_s.rdata = {31'h0, s.auto_ara};
         end else if (addr == `FC_REG_STATUS) begin
            next_s.rdata = {16'h0, s.ara_addr, 6'h0,
                            mgmt.fault_alert_line,
                            s.state != fc_pkg::FC_H_IDLE};
         end else if (addr == `FC_REG_IRQ_STAT) begin
            next_s.rdata = {29'h0, s.stat};
         end else if (addr == `FC_REG_IRQ_EN) begin
            next_s.rdata = {29'h0, s.en};
         end else if (addr >= `FC_REG_DATA
                      && didx < 8'(`FC_DATA_WORDS)) begin
            next_s.rdata = {24'h0, s.rx[didx[4:0]]};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
         s.alert_prev <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign mgmt.cmd_valid = s.cmd_valid;
   assign mgmt.cmd_code = s.code;
   assign mgmt.cmd_data = s.data;
   assign rdata = s.rdata;
   assign irq = s.irq;
endmodule

// File: tb/fc_mgmt_properties.sv
/*
 * Checker for the management link between the host and device ends.
 * Assumes the bench instantiates it once beside the link interface.
 */
`timescale 1ns/1ps
`include "fc_map.svh"
module fc_mgmt_props (
   input wire logic            ref_clk,
   input wire logic            rst_n,
   input wire logic            cmd_valid,
   input wire logic            cmd_ready,
   input wire fc_pkg::fc_cmd_t cmd_code,
   input wire logic [7:0]      cmd_data,
   input wire logic            rsp_valid,
   input wire logic [7:0]      rsp_byte,
   input wire logic            rsp_last,
   input wire logic            alert_o,
   input wire logic            alert_oe,
   input wire logic            fault_alert_line
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Named steps of a transfer
   wire take = cmd_valid && cmd_ready;
   wire ara  = take && cmd_code == fc_pkg::FC_CMD_ARA;
   sequence s_cap_take;
      take && cmd_code == fc_pkg::FC_CMD_CAP_READ;
   endsequence
   sequence s_mid;
      rsp_valid && !rsp_last;
   endsequence
   sequence s_block;
      (rsp_valid && !rsp_last && rsp_byte == `FC_REC_BYTES)
      ##1 s_mid [*8] ##1 s_mid [*8] ##1 s_mid [*5]
      ##1 (rsp_valid && rsp_last);
   endsequence

   // ==========================================================
   // Assertions
   cap_block_a: assert property (s_cap_take |-> ##2 s_block)
      else $error("capture block answer malformed");
   telem_pair_a: assert property (
      take && cmd_code == fc_pkg::FC_CMD_TELEM |-> ##2 s_mid ##1 rsp_last)
      else $error("telemetry answer is not two bytes");
   ara_answer_a: assert property (
      ara |-> ##2 rsp_valid && rsp_last && rsp_byte == {`FC_DEV_ADDR, 1'b0})
      else $error("alert response address answer wrong");
   ready_drop_a: assert property (take |=> !cmd_ready)
      else $error("ready stayed up after a take");
   rsp_start_a: assert property (
      $rose(rsp_valid) |-> $past(take, 2))
      else $error("answer began without a command");
   rsp_quiet_a: assert property (
      !rsp_valid |-> rsp_byte == 8'h00 && !rsp_last)
      else $error("answer lines busy outside an answer");
   alert_wire_a: assert property (
      fault_alert_line == !alert_oe && !alert_o)
      else $error("alert line level does not follow its enable");
   alert_release_a: assert property (
      $fell(alert_oe) |-> $past(ara, 1) || $past(ara, 2) || $past(ara, 3))
      else $error("alert released without a response read");
endmodule

// File: tb/tb_top.sv
/*
 * Self-checking bench joining host and device ends over the link.
 * Assumes the shared map, package and interface files compile first.
 */
`timescale 1ns/1ps
`include "fc_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   mismatches++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end end
module tb_top;
   logic         ref_clk, rst_n, wr, rd, irq;
   logic [7:0]   addr;
   logic [31:0]  wdata, rdata, v, seed = 32'hF75B6288;
   logic [15:0]  vin, vout, iout_avg, iout_peak, duty, temp_int, temp_ext, fsw;
   logic [7:0]   vout_status, iout_status, input_status, temp_status;
   logic [7:0]   comm_memory_logic_status_byte, mfr_status;
   logic         fault_event, fault_shutdown, output_enabled;
   logic         capture_en, record_frozen, flash_busy;
   logic [191:0] r;
   logic [175:0] held, flashed;
   logic [7:0]   exp_q[$];
   int           mismatches, n_tests, fb_cnt;
   // Same byte order as the capture record, byte 0 lowest
   wire  [175:0] live = {vin, vout, iout_avg, iout_peak, duty, temp_int,
      temp_ext, fsw, vout_status, iout_status, input_status, temp_status,
      comm_memory_logic_status_byte, mfr_status};

   fc_mgmt_if mgmt ();
   fc_host fc_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .mgmt(mgmt.host),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
   // Short flash time keeps the run brief
   fc_device #(.FLASH_WR_CYC(20)) fc_device_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .mgmt(mgmt.device), .vin(vin), .vout(vout),
      .iout_avg(iout_avg), .iout_peak(iout_peak), .duty(duty),
      .temp_int(temp_int), .temp_ext(temp_ext), .fsw(fsw),
      .vout_status(vout_status), .iout_status(iout_status),
      .input_status(input_status), .temp_status(temp_status),
      .comm_memory_logic_status_byte(comm_memory_logic_status_byte),
      .mfr_status(mfr_status), .fault_event(fault_event),
      .fault_shutdown(fault_shutdown), .output_enabled(output_enabled),
      .capture_en(capture_en), .record_frozen(record_frozen),
      .flash_busy(flash_busy));
   fc_mgmt_props fc_mgmt_props_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .cmd_valid(mgmt.cmd_valid), .cmd_ready(mgmt.cmd_ready),
      .cmd_code(mgmt.cmd_code), .cmd_data(mgmt.cmd_data),
      .rsp_valid(mgmt.rsp_valid), .rsp_byte(mgmt.rsp_byte),
      .rsp_last(mgmt.rsp_last), .alert_o(mgmt.alert_o),
      .alert_oe(mgmt.alert_oe), .fault_alert_line(mgmt.fault_alert_line));

   // ==========================================================
   // Clock, flash busy counter, watchdog
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (flash_busy === 1'b1) fb_cnt <= fb_cnt + 1;
   // Whole run needs under a thousand cycles; this is over fifty times that
   initial begin
      repeat (50000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end

   // ==========================================================
   // Bus tasks and model helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic rnd_in;
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         r[32*i +: 32] = seed;
      end
      @(posedge ref_clk);
      {vin, vout, iout_avg, iout_peak, duty, temp_int, temp_ext, fsw,
       vout_status, iout_status, input_status, temp_status,
       comm_memory_logic_status_byte, mfr_status} <= r[175:0];
      @(posedge ref_clk);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask
   // Polls busy rather than waiting a fixed time: stores may stall it
   task automatic cmd(input logic [2:0] c, input logic [7:0] d);
      wr_reg(`FC_REG_CMD, {21'h0, c, d});
      for (int i = 0; i < 300; i++) begin
         rd_reg(`FC_REG_STATUS);
         if (v[0] === 1'b0) break;
      end
      `CHK("busy", 1'b0, v[0])
   endtask
   task automatic cmp_rsp;
      for (int i = 0; i < exp_q.size(); i++) begin
         rd_reg(8'h40 + 8'(4 * i));
         `CHK("answer byte", {24'h0, exp_q[i]}, v)
      end
   endtask
   task automatic read_rec(input logic [175:0] rec);
      exp_q = {`FC_REC_BYTES};
      for (int i = 0; i < 22; i++) exp_q.push_back(rec[8*i +: 8]);
      cmd(3'd2, 8'h00);
      cmp_rsp();
   endtask
   task automatic pulse_fault;
      @(posedge ref_clk);
      fault_event <= 1'b1;
      @(posedge ref_clk);
      fault_event <= 1'b0;
   endtask
   task automatic wait_flash;
      for (int i = 0; i < 200; i++) begin
         @(posedge ref_clk);
         if (fb_cnt > 0 && flash_busy === 1'b0) break;
      end
      `CHK("flash cycles", 20, fb_cnt)
      fb_cnt = 0;
   endtask
   task automatic chk_line(input logic lvl);
      rd_reg(`FC_REG_STATUS);
      `CHK("line level", lvl, v[1])
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   initial begin
      {rst_n, wr, rd, fault_event, fault_shutdown, output_enabled} = 6'h01;
      {addr, wdata, r} = '0;
      {vin, vout, iout_avg, iout_peak, duty, temp_int, temp_ext, fsw,
       vout_status, iout_status, input_status, temp_status,
       comm_memory_logic_status_byte, mfr_status} = '0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk_line(1'b1);
      rd_reg(8'hFC);
      `CHK("unmapped", 32'h0, v)
      rnd_in();
      for (int k = 0; k < 8; k++) begin
         exp_q = {live[160 - 16*k +: 8], live[168 - 16*k +: 8]};
         cmd(3'd3, 8'(k));
         cmp_rsp();
      end
      read_rec(176'h0);
      cmd(3'd0, 8'h01);
      `CHK("capture off", 1'b0, capture_en)
      cmd(3'd0, 8'h02);
      `CHK("capture on", 1'b1, capture_en)
      read_rec(live);
      rd_reg(`FC_REG_IRQ_STAT);
      `CHK("done flag", 1'b1, v[0])
      `CHK("masked irq", 1'b0, irq)
      wr_reg(`FC_REG_IRQ_EN, 32'h1);
      repeat (2) @(posedge ref_clk);
      `CHK("irq raised", 1'b1, irq)
      wr_reg(`FC_REG_IRQ_CLR, 32'h1);
      wr_reg(`FC_REG_IRQ_EN, 32'h2);
      repeat (2) @(posedge ref_clk);
      `CHK("irq cleared", 1'b0, irq)
      fault_shutdown <= 1'b1;
      held = live;
      pulse_fault();
      wait_flash();
      `CHK("frozen", 1'b1, record_frozen)
      `CHK("alert irq", 1'b1, irq)
      chk_line(1'b0);
      rnd_in();
      read_rec(held);
      exp_q = {{`FC_DEV_ADDR, 1'b0}};
      cmd(3'd4, 8'h00);
      cmp_rsp();
      chk_line(1'b1);
      cmd(3'd0, 8'h02);
      fault_shutdown <= 1'b0;
      pulse_fault();
      pulse_fault();
      repeat (30) @(posedge ref_clk);
      `CHK("retry no store", 0, fb_cnt)
      cmd(3'd4, 8'h00);
      chk_line(1'b0);
      cmd(3'd4, 8'h00);
      chk_line(1'b1);
      cmd(3'd1, 8'h02);
      repeat (30) @(posedge ref_clk);
      `CHK("store refused", 0, fb_cnt)
      output_enabled <= 1'b0;
      rnd_in();
      flashed = live;
      cmd(3'd1, 8'h02);
      wait_flash();
      rnd_in();
      cmd(3'd1, 8'h01);
      read_rec(flashed);
      `CHK("loaded frozen", 1'b1, record_frozen)
      wr_reg(`FC_REG_CTRL, 32'h1);
      pulse_fault();
      repeat (8) @(posedge ref_clk);
      chk_line(1'b1);
      exp_q = {{`FC_DEV_ADDR, 1'b0}};
      cmp_rsp();
      summarize();
   end
endmodule
